//--- verilog/bmcr_pkg.sv
// Package: register map, field layout and shared types of the bus and modem control registers
package bmcr_pkg;

  // ==========================================================================
  // Register address pointer
  // ==========================================================================
  localparam int unsigned   PTR_SEL_LSB     = 1;           // Select field sits in pointer bits 3..1
  localparam int unsigned   PTR_SEL_W       = 3;
  localparam logic [2:0]    SEL_BUS_MASTER  = 3'h4;        // Index of bus_master_config
  localparam logic [2:0]    SEL_MODEM_LINE  = 3'h5;        // Index of modem_line_control
  localparam logic [15:0]   PTR_RESET       = 16'h0000;
  localparam logic [15:0]   PTR_WRITE_MASK  = 16'h000e;    // Only the select field is stored

  // ==========================================================================
  // bus_master_config field positions
  // ==========================================================================
  localparam int unsigned   BMC_CTRL_ORDER  = 5;
  localparam int unsigned   BMC_BURST_LSB   = 3;
  localparam int unsigned   BMC_DATA_ORDER  = 2;
  localparam int unsigned   BMC_STROBE_POL  = 1;
  localparam int unsigned   BMC_PIN_FUNC    = 0;

  // ==========================================================================
  // modem_line_control field positions
  // ==========================================================================
  localparam int unsigned   MLC_HS_EN       = 4;
  localparam int unsigned   MLC_TERM_DIR    = 3;
  localparam int unsigned   MLC_SET_DIR     = 2;
  localparam int unsigned   MLC_TERM_VAL    = 1;
  localparam int unsigned   MLC_SET_VAL     = 0;

  // ==========================================================================
  // Burst field encodings and transfer limits
  // ==========================================================================
  localparam logic [1:0]    BURST_SHORT     = 2'b00;
  localparam logic [1:0]    BURST_UNLIMITED = 2'b01;
  localparam logic [1:0]    BURST_LONG      = 2'b10;
  localparam logic [4:0]    LIM_SHORT_BYTES = 5'h02;       // 2 bytes in 8-bit mode
  localparam logic [4:0]    LIM_SHORT_WORDS = 5'h01;       // 1 word in 16-bit mode
  localparam logic [4:0]    LIM_LONG_BYTES  = 5'h10;       // 16 bytes in 8-bit mode
  localparam logic [4:0]    LIM_LONG_WORDS  = 5'h08;       // 8 words in 16-bit mode

  // Frame spacing above which the send request drops between frames
  localparam logic [5:0]    SPACING_KEEP_MAX = 6'h02;

  // ==========================================================================
  // Types
  // ==========================================================================
  typedef struct packed {
    logic       ctrl_byte_order;
    logic [1:0] burst;
    logic       data_byte_order;
    logic       strobe_polarity_sel;
    logic       bus_pin_function_sel;
  } bmcr_bus_cfg_t;

  typedef struct packed {
    logic       send_handshake_enable;
    logic       term_ready_dir;
    logic       set_ready_dir;
    logic       term_ready_val;
    logic       set_ready_val;
  } bmcr_modem_cfg_t;

  localparam bmcr_bus_cfg_t   BUS_CFG_RESET   = '0;
  localparam bmcr_modem_cfg_t MODEM_CFG_RESET = '0;

endpackage

//--- verilog/bmcr_byte_mapper.sv
// Even/odd byte lane mapper for one DMA data direction
`timescale 1ns/1ps

module bmcr_byte_mapper (
  input  wire logic        order_low_even,
  input  wire logic        byte_xfer,
  input  wire logic        byte_addr0,
  input  wire logic [15:0] word_in,
  output logic      [15:0] word_out,
  output logic      [1:0]  lane_en
);

  // ==========================================================================
  // Lane steering
  // ==========================================================================
  // Input is in address order: [7:0] is the even byte, [15:8] the odd byte
  wire logic [15:0] swapped  = {word_in[7:0], word_in[15:8]};
  wire logic        hi_lane  = byte_addr0 ^ ~order_low_even;   // Lane that holds the addressed byte

  // Swap is its own inverse, so one mapper serves reads and writes alike
  assign word_out = order_low_even ? word_in : swapped;
  assign lane_en  = byte_xfer ? {hi_lane, ~hi_lane} : 2'b11;

endmodule

//--- verilog/bmcr_burst_limiter.sv
// Counts DMA transfers within one bus tenure and flags when the burst limit is met
`timescale 1ns/1ps

module bmcr_burst_limiter (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic [1:0] burst_sel,
  input  wire logic       mode_16bit,
  input  wire logic       bus_owned,
  input  wire logic       xfer_done,
  output logic            limit_reached
);

  logic [4:0] count_q;
  logic [4:0] count_d;

  // ==========================================================================
  // Limit decode
  // ==========================================================================
  // Unused code 11 is treated as the short burst, the safe choice for bus sharing
  wire logic       unlimited = (burst_sel == bmcr_pkg::BURST_UNLIMITED);
  wire logic [4:0] lim_long  = mode_16bit ? bmcr_pkg::LIM_LONG_WORDS : bmcr_pkg::LIM_LONG_BYTES;
  wire logic [4:0] lim_short = mode_16bit ? bmcr_pkg::LIM_SHORT_WORDS : bmcr_pkg::LIM_SHORT_BYTES;
  wire logic [4:0] limit     = (burst_sel == bmcr_pkg::BURST_LONG) ? lim_long : lim_short;

  // Count restarts each time the bus is given back
  assign count_d       = !bus_owned ? 5'h00 :
                         (xfer_done && !limit_reached) ? count_q + 5'h01 : count_q;
  assign limit_reached = !unlimited && (count_q >= limit);

  // Transfer counter
  always_ff @(posedge clk) begin
    if (rst) begin
      count_q <= 5'h00;
    end else begin
      count_q <= count_d;
    end
  end

endmodule

//--- verilog/bmcr_regs.sv
// Bus master configuration and modem line control registers with their pin logic
`timescale 1ns/1ps

// Notes on behaviour
// - Control order 1: bits 7..0 at even addresses, 0 swaps them.
// - Control order bit touches only init block, descriptor and status traffic.
// - Data order bit maps bytes the same way, only for data buffers.
// - Burst field caps transfers per bus tenure.
// - 00 is 2 bytes or 1 word, 10 is 16 bytes or 8 words, 01 unlimited.
// - Strobe bit 0 gives active high latch enable, 1 active low strobe.
// - Pin function bit swaps masks and hold for grant, byte select, request; bus_request_out here follows hold_req_act in both settings.
// - Reset clears control order, burst, strobe and pin function; all read/write.
// - Pointer select 5 reaches modem control; bits 15..5 reserved, written zero.
// - Handshake enable makes terminal pin send request, set pin clear input.
// - Send request low while data waits and throughout transmission.
// - After closing flag, request rises if no frame waits or spacing exceeds 2.
// - Clear-to-send high blocks transmit start and holds serial output high.
// - Terminal direction 0 makes pin input, 1 drives it from value bit.
// - Set direction 0 makes pin input, 1 drives it from value bit.
// - Terminal value bit reads pin when input, writable and driven when output.
// - Set value bit reads pin when input, writable and driven when output.
module bmcr_regs (
  input  wire logic        clk,
  input  wire logic        rst,
  // Host slave port
  input  wire logic        host_cs,
  input  wire logic        host_ptr_sel,
  input  wire logic        host_wr,
  input  wire logic        host_rd,
  input  wire logic [15:0] host_wdata,
  output logic      [15:0] host_rdata,
  // DMA datapath from the core
  input  wire logic        dma_is_data,
  input  wire logic        dma_byte_xfer,
  input  wire logic        dma_byte_addr0,
  input  wire logic        dma_mode_16bit,
  input  wire logic [15:0] dma_wr_word,
  output logic      [15:0] dma_rd_word,
  input  wire logic        dma_bus_owned,
  input  wire logic        dma_xfer_done,
  output logic             dma_burst_end,
  // DMA datapath to the memory bus
  output logic      [15:0] mem_wr_word,
  input  wire logic [15:0] mem_rd_word,
  // Bus control pins
  input  wire logic        addr_strobe_act,
  output logic             addr_strobe_out,
  output logic             addr_strobe_oe,
  output logic             low_byte_mask_out,
  output logic             low_byte_mask_oe,
  input  wire logic        high_byte_mask_in,
  output logic             high_byte_mask_out,
  output logic             high_byte_mask_oe,
  input  wire logic        hold_req_act,
  output logic             bus_request_out,
  output logic             bus_grant_in_seen,
  // Transmit side of the serial core
  input  wire logic        tx_frame_pending,
  input  wire logic        tx_active,
  input  wire logic        tx_closing_flag_done,
  input  wire logic        tx_more_frames,
  input  wire logic [5:0]  tx_min_spacing,
  input  wire logic        tx_core_bit,
  output logic             tx_start_allow,
  output logic             tx_serial_out,
  // Modem pins
  input  wire logic        term_ready_in,
  output logic             term_ready_out,
  output logic             term_ready_oe,
  input  wire logic        set_ready_in,
  output logic             set_ready_out,
  output logic             set_ready_oe
);

  // ==========================================================================
  // State
  // ==========================================================================
  typedef enum logic [1:0] {
    SEND_IDLE = 2'b01,                                   // Send request released (pin high)
    SEND_REQ  = 2'b10                                    // Send request asserted (pin low)
  } bmcr_send_state_t;

  logic [15:0]               ptr_q;
  logic [15:0]               ptr_d;
  bmcr_pkg::bmcr_bus_cfg_t   bus_cfg_q;
  bmcr_pkg::bmcr_bus_cfg_t   bus_cfg_d;
  bmcr_pkg::bmcr_modem_cfg_t modem_cfg_q;
  bmcr_pkg::bmcr_modem_cfg_t modem_cfg_d;
  bmcr_send_state_t          send_q;
  bmcr_send_state_t          send_d;
  logic [15:0]               rdata_q;
  logic [15:0]               rdata_d;
  logic [15:0]               mem_wr_q;
  logic [15:0]               dma_rd_q;
  logic                      tx_out_q;
  logic                      tx_out_d;

  // ==========================================================================
  // Host access decode
  // ==========================================================================
  wire logic [2:0]  sel       = ptr_q[bmcr_pkg::PTR_SEL_LSB +: bmcr_pkg::PTR_SEL_W];
  wire logic        ptr_wr    = host_cs && host_wr && host_ptr_sel;
  wire logic        data_wr   = host_cs && host_wr && !host_ptr_sel;
  wire logic        data_rd   = host_cs && host_rd && !host_ptr_sel;
  wire logic        ptr_rd    = host_cs && host_rd && host_ptr_sel;
  wire logic        bus_wr    = data_wr && (sel == bmcr_pkg::SEL_BUS_MASTER);
  wire logic        modem_wr  = data_wr && (sel == bmcr_pkg::SEL_MODEM_LINE);

  // Pointer keeps only its select field; other bits belong to registers outside this block
  assign ptr_d = ptr_wr ? (host_wdata & bmcr_pkg::PTR_WRITE_MASK) : ptr_q;

  // ==========================================================================
  // bus_master_config
  // ==========================================================================
  // Every field is plain read/write; reserved bits are dropped on write
  always_comb begin
    bus_cfg_d = bus_cfg_q;
    if (bus_wr) begin
      bus_cfg_d.ctrl_byte_order      = host_wdata[bmcr_pkg::BMC_CTRL_ORDER];
      bus_cfg_d.burst                = host_wdata[bmcr_pkg::BMC_BURST_LSB +: 2];
      bus_cfg_d.data_byte_order      = host_wdata[bmcr_pkg::BMC_DATA_ORDER];
      bus_cfg_d.strobe_polarity_sel  = host_wdata[bmcr_pkg::BMC_STROBE_POL];
      bus_cfg_d.bus_pin_function_sel = host_wdata[bmcr_pkg::BMC_PIN_FUNC];
    end
  end

  wire logic [15:0] bus_rd_word = {10'h000,
                                   bus_cfg_q.ctrl_byte_order,
                                   bus_cfg_q.burst,
                                   bus_cfg_q.data_byte_order,
                                   bus_cfg_q.strobe_polarity_sel,
                                   bus_cfg_q.bus_pin_function_sel};

  // ==========================================================================
  // modem_line_control
  // ==========================================================================
  // Handshake mode overrides both directions: terminal pin drives, set pin listens
  wire logic hs_en     = modem_cfg_q.send_handshake_enable;
  wire logic term_out  = hs_en || modem_cfg_q.term_ready_dir;
  wire logic set_out   = !hs_en && modem_cfg_q.set_ready_dir;

  // Value bits only take writes that also set their direction bit to output
  always_comb begin
    modem_cfg_d = modem_cfg_q;
    if (modem_wr) begin
      modem_cfg_d.send_handshake_enable = host_wdata[bmcr_pkg::MLC_HS_EN];
      modem_cfg_d.term_ready_dir        = host_wdata[bmcr_pkg::MLC_TERM_DIR];
      modem_cfg_d.set_ready_dir         = host_wdata[bmcr_pkg::MLC_SET_DIR];
      if (host_wdata[bmcr_pkg::MLC_TERM_DIR]) begin
        modem_cfg_d.term_ready_val = host_wdata[bmcr_pkg::MLC_TERM_VAL];
      end
      if (host_wdata[bmcr_pkg::MLC_SET_DIR]) begin
        modem_cfg_d.set_ready_val = host_wdata[bmcr_pkg::MLC_SET_VAL];
      end
    end
  end

  // Input direction returns the live pin level instead of the stored bit
  wire logic term_rd_val = modem_cfg_q.term_ready_dir ? modem_cfg_q.term_ready_val : term_ready_in;
  wire logic set_rd_val  = modem_cfg_q.set_ready_dir ? modem_cfg_q.set_ready_val : set_ready_in;

  wire logic [15:0] modem_rd_word = {11'h000,
                                     modem_cfg_q.send_handshake_enable,
                                     modem_cfg_q.term_ready_dir,
                                     modem_cfg_q.set_ready_dir,
                                     term_rd_val,
                                     set_rd_val};

  // ==========================================================================
  // Read data mux
  // ==========================================================================
  // Selections served elsewhere in the chip read as zero here
  assign rdata_d = ptr_rd ? ptr_q :
                   !data_rd ? rdata_q :
                   (sel == bmcr_pkg::SEL_BUS_MASTER) ? bus_rd_word :
                   (sel == bmcr_pkg::SEL_MODEM_LINE) ? modem_rd_word : 16'h0000;
  assign host_rdata = rdata_q;

  // ==========================================================================
  // DMA byte ordering
  // ==========================================================================
  // Data buffers follow the data order bit, everything else the control bit
  wire logic       order_sel = dma_is_data ? bus_cfg_q.data_byte_order
                                           : bus_cfg_q.ctrl_byte_order;
  wire logic [15:0] wr_mapped;
  wire logic [15:0] rd_mapped;
  wire logic [1:0]  lane_en;

  bmcr_byte_mapper u_wr_map (
    .order_low_even (order_sel),
    .byte_xfer      (dma_byte_xfer),
    .byte_addr0     (dma_byte_addr0),
    .word_in        (dma_wr_word),
    .word_out       (wr_mapped),
    .lane_en        (lane_en)
  );

  bmcr_byte_mapper u_rd_map (
    .order_low_even (order_sel),
    .byte_xfer      (dma_byte_xfer),
    .byte_addr0     (dma_byte_addr0),
    .word_in        (mem_rd_word),
    .word_out       (rd_mapped),
    .lane_en        ()
  );

  assign mem_wr_word = mem_wr_q;
  assign dma_rd_word = dma_rd_q;

  // ==========================================================================
  // Burst limit
  // ==========================================================================
  bmcr_burst_limiter u_burst (
    .clk           (clk),
    .rst           (rst),
    .burst_sel     (bus_cfg_q.burst),
    .mode_16bit    (dma_mode_16bit),
    .bus_owned     (dma_bus_owned),
    .xfer_done     (dma_xfer_done),
    .limit_reached (dma_burst_end)
  );

  // ==========================================================================
  // Bus control pins
  // ==========================================================================
  // Strobe pins float unless this device masters the bus
  assign addr_strobe_out = bus_cfg_q.strobe_polarity_sel ? !addr_strobe_act : addr_strobe_act;
  assign addr_strobe_oe  = dma_bus_owned;

  // Masks are active high on the pins: a set bit blocks that lane
  wire logic pin_alt = bus_cfg_q.bus_pin_function_sel;
  assign low_byte_mask_out  = pin_alt ? dma_byte_xfer : !lane_en[0];
  assign low_byte_mask_oe   = dma_bus_owned;
  assign high_byte_mask_out = pin_alt ? 1'b0 : !lane_en[1];
  assign high_byte_mask_oe  = dma_bus_owned && !pin_alt;
  assign bus_grant_in_seen  = pin_alt && high_byte_mask_in;
  assign bus_request_out    = hold_req_act;

  // ==========================================================================
  // Send request sequencing
  // ==========================================================================
  wire logic spacing_wide = (tx_min_spacing > bmcr_pkg::SPACING_KEEP_MAX);
  wire logic release_req  = tx_closing_flag_done && (!tx_more_frames || spacing_wide);
  wire logic cts_high     = hs_en && set_ready_in;

  // A release with another frame already queued re-arms on the next cycle
  always_comb begin
    send_d = send_q;
    unique case (send_q)
      SEND_IDLE: begin
        if (hs_en && (tx_frame_pending || tx_active)) begin
          send_d = SEND_REQ;
        end
      end
      SEND_REQ: begin
        if (!hs_en || (release_req && !tx_active)) begin
          send_d = SEND_IDLE;
        end
      end
    endcase
  end

  // Pin is low-true: low while a request stands
  wire logic send_req_pin = (send_q == SEND_REQ) ? 1'b0 : 1'b1;

  assign tx_start_allow = !hs_en || ((send_q == SEND_REQ) && !set_ready_in);

  // Idle line is marking; clear-to-send high forces ones regardless of core state
  assign tx_out_d      = cts_high ? 1'b1 : tx_core_bit;
  assign tx_serial_out = tx_out_q;

  // ==========================================================================
  // Modem pin drive
  // ==========================================================================
  assign term_ready_out = hs_en ? send_req_pin : modem_cfg_q.term_ready_val;
  assign term_ready_oe  = term_out;
  assign set_ready_out  = modem_cfg_q.set_ready_val;
  assign set_ready_oe   = set_out;

  // ==========================================================================
  // Registers
  // ==========================================================================
  // Configuration and pointer
  always_ff @(posedge clk) begin
    if (rst) begin
      ptr_q       <= bmcr_pkg::PTR_RESET;
      bus_cfg_q   <= bmcr_pkg::BUS_CFG_RESET;
      modem_cfg_q <= bmcr_pkg::MODEM_CFG_RESET;
    end else begin
      ptr_q       <= ptr_d;
      bus_cfg_q   <= bus_cfg_d;
      modem_cfg_q <= modem_cfg_d;
    end
  end

  // Sequencer and host read data
  always_ff @(posedge clk) begin
    if (rst) begin
      send_q  <= SEND_IDLE;
      rdata_q <= 16'h0000;
    end else begin
      send_q  <= send_d;
      rdata_q <= rdata_d;
    end
  end

  // Datapath flops: one cycle of latency on both DMA directions and the serial bit
  always_ff @(posedge clk) begin
    if (rst) begin
      mem_wr_q <= 16'h0000;
      dma_rd_q <= 16'h0000;
      tx_out_q <= 1'b1;
    end else begin
      mem_wr_q <= wr_mapped;
      dma_rd_q <= rd_mapped;
      tx_out_q <= tx_out_d;
    end
  end

endmodule

//--- tb/bmcr_modem_model.sv
// Modem model: far end of the two modem control pins
`timescale 1ns/1ps
module bmcr_modem_model (
  input  wire logic term_ready_oe,
  input  wire logic term_ready_out,
  input  wire logic set_ready_oe,
  input  wire logic set_ready_out,
  input  wire logic m_term,
  input  wire logic m_set,
  output logic      term_ready_in,
  output logic      set_ready_in
);
  // ==========================================================================
  // Pin resolution
  // ==========================================================================
  // Released pin shows the modem's level
  assign term_ready_in = term_ready_oe ? term_ready_out : m_term;
  assign set_ready_in  = set_ready_oe ? set_ready_out : m_set;
endmodule

//--- tb/bmcr_regs_checker.sv
// Checker: port level properties of the bus and modem control registers
`timescale 1ns/1ps
module bmcr_regs_checker (
  input wire logic clk,
  input wire logic rst,
  input wire logic host_wr,
  input wire logic dma_bus_owned,
  input wire logic dma_xfer_done,
  input wire logic dma_burst_end,
  input wire logic addr_strobe_act,
  input wire logic addr_strobe_out,
  input wire logic addr_strobe_oe,
  input wire logic hold_req_act,
  input wire logic bus_request_out,
  input wire logic tx_frame_pending,
  input wire logic tx_active,
  input wire logic tx_closing_flag_done,
  input wire logic tx_more_frames,
  input wire logic tx_start_allow,
  input wire logic tx_serial_out,
  input wire logic term_ready_out,
  input wire logic term_ready_oe,
  input wire logic set_ready_in,
  input wire logic set_ready_oe
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // ==========================================================================
  // Bus master pins and burst counter
  // ==========================================================================
  AST_BUS_OE: assert property (addr_strobe_oe == dma_bus_owned)
    else $error("strobe enable differs from bus ownership");
  AST_STROBE_FOLLOW: assert property ($changed(addr_strobe_act) && !$past(host_wr) |-> $changed(addr_strobe_out))
    else $error("strobe pin stuck");
  AST_HOLD_PASS: assert property (bus_request_out == hold_req_act)
    else $error("bus request differs from hold");
  AST_BURST_CLEAR: assert property (!dma_bus_owned |=> !dma_burst_end)
    else $error("burst end without bus tenure");
  AST_BURST_CAUSE: assert property ($rose(dma_burst_end) |-> $past(dma_xfer_done))
    else $error("burst end without a transfer");
  // ==========================================================================
  // Send handshake
  // ==========================================================================
  AST_HS_PINS: assert property (!tx_start_allow |-> term_ready_oe && !set_ready_oe)
    else $error("handshake directions");
  AST_IDLE_HIGH: assert property (!tx_start_allow && !set_ready_in |-> term_ready_out)
    else $error("send request low while idle");
  AST_REQ_LOW: assert property (!tx_start_allow && tx_frame_pending && !tx_closing_flag_done && !host_wr
    |=> !term_ready_out)
    else $error("send request not raised");
  AST_REQ_DROP: assert property (term_ready_oe && !set_ready_oe && !term_ready_out && tx_closing_flag_done
    && !tx_more_frames && !tx_active
    && !tx_frame_pending && !host_wr |=> term_ready_out)
    else $error("send request kept");
  AST_CTS_HOLD: assert property ((!tx_start_allow && set_ready_in) [*2] |-> tx_serial_out)
    else $error("serial low under clear");
  C_BURST: cover property (dma_burst_end);
  C_REQ: cover property (!tx_start_allow && !term_ready_out);
  C_DROP: cover property ($rose(term_ready_out));
endmodule

bind bmcr_regs bmcr_regs_checker i_chk (.*);

//--- tb/tb_bmcr_regs.sv
// Testbench: register access, byte order, burst, bus pins and modem handshake
`timescale 1ns/1ps
module tb_bmcr_regs;
  logic clk = 0, rst = 1, host_cs = 0, host_ptr_sel = 0, host_wr = 0, host_rd = 0, dma_is_data = 0;
  logic dma_byte_xfer = 0, dma_byte_addr0 = 0, dma_mode_16bit = 0, dma_bus_owned = 0, dma_xfer_done = 0;
  logic addr_strobe_act = 0, high_byte_mask_in = 0, hold_req_act = 0, tx_frame_pending = 0, tx_active = 0;
  logic tx_closing_flag_done = 0, tx_more_frames = 0, tx_core_bit = 0, m_term = 0, m_set = 0;
  logic [15:0] host_wdata = 16'h0000, dma_wr_word = 16'h0000, mem_rd_word = 16'h0000;
  logic [15:0] host_rdata, dma_rd_word, mem_wr_word;
  logic [5:0]  tx_min_spacing = 6'h00;
  logic dma_burst_end, addr_strobe_out, addr_strobe_oe, low_byte_mask_out, low_byte_mask_oe, high_byte_mask_out;
  logic high_byte_mask_oe, bus_request_out, bus_grant_in_seen, tx_start_allow, tx_serial_out;
  logic term_ready_in, term_ready_out, term_ready_oe, set_ready_in, set_ready_out, set_ready_oe;
  int   errors = 0, n_checks = 0, cyc = 0, k, n;

  bmcr_regs i_dut (.*);
  bmcr_modem_model i_modem (.*);

  // ==========================================================================
  // Clock, hang guard and verdict
  // ==========================================================================
  always #2 clk = ~clk;
  // Ceiling far above the few hundred cycles needed
  always @(posedge clk) begin
    cyc++;
    if (cyc == 10000) begin
      errors++;
      complete_run();
    end
  end
  task automatic complete_run();
    $display("checks %0d errors %0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask
  // ==========================================================================
  // Access tasks
  // ==========================================================================
  task automatic tick(input int c);
    repeat (c) @(posedge clk);
    #1;
  endtask
  task automatic chk(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e) begin
      errors++;
      $display("Error at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  // One-cycle request held across its edge
  task automatic acc(input logic p, input logic w, input logic [15:0] d);
    tick(1);
    {host_cs, host_ptr_sel, host_wr, host_rd, host_wdata} = {1'b1, p, w, !w, d};
    tick(1);
    {host_cs, host_wr, host_rd} = 3'b000;
  endtask
  task automatic wreg(input logic [2:0] s, input logic [15:0] d);
    acc(1, 1, {12'h000, s, 1'b0});
    acc(0, 1, d);
  endtask
  task automatic rreg(input logic [2:0] s, input logic [15:0] e);
    acc(1, 1, {12'h000, s, 1'b0});
    acc(0, 0, 16'h0000);
    tick(1);
    chk(host_rdata, e);
  endtask
  // ==========================================================================
  // Scenarios
  // ==========================================================================
  initial begin
    tick(8);
    rst = 0;
    rreg(3'h4, 16'h0000);
    wreg(3'h4, 16'hffff);
    rreg(3'h4, 16'h003f);
    wreg(3'h5, 16'hffe0);
    rreg(3'h5, 16'h0000);
    rst = 1;
    tick(2);
    rst = 0;
    rreg(3'h4, 16'h0000);
    // Both order bits against both transfer kinds, in both directions
    for (k = 0; k < 8; k++) begin
      wreg(3'h4, {10'h000, k[1], 2'b00, k[0], 2'b00});
      {dma_is_data, dma_wr_word, mem_rd_word} = {k[2], 16'h12a5, 16'h12a5};
      tick(2);
      chk(mem_wr_word, (k[2] ? k[0] : k[1]) ? 16'h12a5 : 16'ha512);
      chk(dma_rd_word, (k[2] ? k[0] : k[1]) ? 16'h12a5 : 16'ha512);
    end
    // Strobe polarity and pin function in all four combinations
    for (k = 0; k < 4; k++) begin
      wreg(3'h4, {14'h0000, k[0], k[1]});
      {addr_strobe_act, high_byte_mask_in, hold_req_act, dma_bus_owned} = {k[1], 1'b1, k[0], 1'b1};
      tick(1);
      chk(addr_strobe_out, k[1] ^ k[0]);
      chk({bus_grant_in_seen, high_byte_mask_oe, bus_request_out}, {k[1], !k[1], k[0]});
    end
    // Burst codes 00, 10, 01 in byte and word mode; unlimited runs to the cap
    for (k = 0; k < 6; k++) begin
      wreg(3'h4, {11'h000, k[1], k[2], 3'h0});
      {dma_mode_16bit, dma_bus_owned} = {k[0], 1'b0};
      tick(2);
      dma_bus_owned = 1;
      n = 0;
      while (dma_burst_end !== 1'b1 && n < 20) begin
        dma_xfer_done = 1;
        tick(1);
        dma_xfer_done = 0;
        n++;
        tick(1);
      end
      chk(n, k < 2 ? (k[0] ? 1 : 2) : k < 4 ? (k[0] ? 8 : 16) : 20);
    end
    dma_bus_owned = 0;
    // Modem pins as outputs, then as inputs with writes to value bits ignored
    wreg(3'h5, 16'h000f);
    rreg(3'h5, 16'h000f);
    chk({term_ready_oe, term_ready_out, set_ready_oe, set_ready_out}, 4'hf);
    m_term = 1;
    wreg(3'h5, 16'h0003);
    rreg(3'h5, 16'h0002);
    chk({term_ready_oe, set_ready_oe}, 2'b00);
    // Handshake: closing flag with no frame, spacing 3, then spacing 2 with more
    for (k = 0; k < 3; k++) begin
      wreg(3'h5, 16'h0010);
      {m_set, tx_frame_pending} = 2'b11;
      tick(3);
      chk({tx_start_allow, term_ready_out, tx_serial_out}, 3'b001);
      m_set = 0;
      tick(1);
      chk(tx_start_allow, 1);
      {tx_active, tx_frame_pending} = 2'b10;
      tick(3);
      chk({term_ready_out, tx_serial_out}, 2'b00);
      {tx_active, tx_more_frames, tx_min_spacing} = {1'b0, k != 0, k == 1 ? 6'h03 : 6'h02};
      tx_closing_flag_done = 1;
      tick(1);
      tx_closing_flag_done = 0;
      tick(1);
      chk(term_ready_out, k != 2);
      tx_more_frames = 0;
      wreg(3'h5, 16'h0000);
    end
    complete_run();
  end
endmodule
